// ---- core/config_store_lock_readout.sv ----
`timescale 1ns/1ps
`include "config_store_params.svh"

module config_store_lock_readout
  import config_store_pkg::*;
#(
  parameter logic [12:0] FACTORY_WORD0 = 13'h0000, // Arbitrary factory value
  parameter logic [12:0] FACTORY_WORD1 = 13'h0001, // Arbitrary factory value
  parameter logic [12:0] FACTORY_WORD2 = 13'h0002, // Arbitrary factory value
  parameter logic [12:0] FACTORY_WORD3 = 13'h0003 // Arbitrary factory value
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic nvm_init,
  input wire cmd_s cmd,
  input wire logic [13:0] field_value,
  output rsp_s rsp,
  output logic locked,
  output logic lock_programmed,
  output logic [9:0] mode_config,
  output logic [2:0] output_format_select,
  output logic [51:0] user_store_image
);

  // Working copies, seen by the signal path
  logic [12:0] user_store_ff [4];
  logic [9:0] mode_ff;
  // Nonvolatile image, survives rst (power cycle)
  // Cleared only by the factory fill input
  logic [12:0] nv_store_ff [4];
  logic [9:0] nv_mode_ff;
  logic nv_lock_ff;
  // Lock state fixed at power-up
  // Sample flag blocks commands in the first cycle after rst
  logic lock_active_ff;
  logic lock_sample_ff;
  // Answer registers
  rsp_s rsp_ff;
  // Decoded command terms
  logic accept;
  logic do_write;
  logic do_store;
  logic do_read;
  logic [12:0] factory [4];
  // Read path terms
  logic [13:0] field_reversed;
  logic [15:0] nxt_rsp_data;

  // Factory words as a table, so the fill loop can index them like the image
  assign factory[0] = FACTORY_WORD0;
  assign factory[1] = FACTORY_WORD1;
  assign factory[2] = FACTORY_WORD2;
  assign factory[3] = FACTORY_WORD3;

  // Commands count only once the lock sample is settled
  // In the sample cycle the lock state is not yet known, so refuse
  // Limitation: no flag for out-of-order word access, the programmer owns it
  assign accept = cmd.valid && !lock_sample_ff && !lock_active_ff;
  // One kind per telegram, so at most one term is high
  assign do_write = accept && (cmd.kind == CMD_WRITE);
  assign do_store = accept && (cmd.kind == CMD_STORE);
  assign do_read = accept && (cmd.kind == CMD_READ);

  // Field word goes out LSB first relative to other registers
  // Pure rewiring, costs no logic
  always_comb
  begin
    for (int i = 0; i < `FIELD_W; i++)
    begin
      field_reversed[i] = field_value[`FIELD_W - 1 - i];
    end
  end

  // Factory fill of the nonvolatile image; rst leaves it alone
  // Trade-off: image kept in flops, no write time or wear modelled
  always_ff @(posedge clk)
  begin
    if (nvm_init)
    begin
      // Blank die only; no telegram reaches this path
      for (int i = 0; i < `USER_STORE_WORDS; i++)
      begin
        nv_store_ff[i] <= factory[i];
      end
      nv_mode_ff <= `MODE_RESET;
    end
    else if (do_store)
    begin
      // One store commits all four words at once
      for (int i = 0; i < `USER_STORE_WORDS; i++)
      begin
        nv_store_ff[i] <= user_store_ff[i];
      end
      nv_mode_ff <= mode_ff;
    end
  end

  // Lock bit in the image: set only, never cleared by a command
  always_ff @(posedge clk)
  begin
    if (nvm_init)
    begin
      // Blank die leaves the part open
      nv_lock_ff <= 1'b0;
    end
    else if (do_write && (cmd.addr == `ADDR_PERMANENT_LOCK) && cmd.data[0])
    begin
      // Only a one in bit 0 gets here; a zero is ignored
      // No branch but the factory fill ever writes a zero
      nv_lock_ff <= 1'b1;
    end
  end

  // Power-up sample of the stored lock, held until next rst
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // Refuse commands until the sample is taken
      lock_sample_ff <= 1'b1;
      lock_active_ff <= 1'b0;
    end
    else if (lock_sample_ff)
    begin
      // Taken once; a lock set later waits for the next power cycle
      lock_sample_ff <= 1'b0;
      lock_active_ff <= nv_lock_ff;
    end
  end

  // User store words: reload from image at power-up, then writable
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < `USER_STORE_WORDS; i++)
      begin
        // Unstored writes are lost, as on a real power cycle
        user_store_ff[i] <= nv_store_ff[i];
      end
    end
    else if (do_write && (cmd.addr <= `ADDR_USER_STORE3))
    begin
      // Order of words is the programmer's duty; any word is taken
      user_store_ff[cmd.addr[1:0]] <= cmd.data[12:0];
    end
  end

  // Mode configuration; frozen once locked because accept is low
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // Last stored mode comes back
      mode_ff <= nv_mode_ff;
    end
    else if (do_write && (cmd.addr == `ADDR_MODE_CONFIG))
    begin
      // Upper data bits carry nothing for this register
      mode_ff <= cmd.data[9:0];
    end
  end

  // Read data selection
  always_comb
  begin
    // Unmapped indices fall through to zero
    nxt_rsp_data = `DATA_ZERO;
    if (cmd.addr <= `ADDR_USER_STORE3)
    begin
      // User store words
      nxt_rsp_data = {3'h0, user_store_ff[cmd.addr[1:0]]};
    end
    else if (cmd.addr == `ADDR_MODE_CONFIG)
    begin
      // Mode register as written, not as stored
      nxt_rsp_data = {6'h00, mode_ff};
    end
    else if (cmd.addr == `ADDR_PERMANENT_LOCK)
    begin
      // Stored lock bit, so a pending lock reads back at once
      nxt_rsp_data = {15'h0000, nv_lock_ff};
    end
    else if (cmd.addr == `ADDR_FIELD_VALUE)
    begin
      // Other formats carry a different signal, so read as zero
      if (mode_ff[`FORMAT_MSB:`FORMAT_LSB] == `FORMAT_PLAIN_ANALOG)
      begin
        nxt_rsp_data = {2'h0, field_reversed};
      end
    end
  end

  // Answer: one-cycle pulse per accepted read; silence when locked
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // No answer pending after a power cycle
      rsp_ff <= '0;
    end
    else
    begin
      // Valid for one cycle, data held until the next answer
      rsp_ff.valid <= do_read;
      if (do_read)
      begin
        rsp_ff.data <= nxt_rsp_data;
      end
    end
  end

  // Outputs straight from flip-flops
  // Image packs word 0 in the low bits
  assign rsp = rsp_ff;
  // Lock in force this power-up, not the stored bit
  assign locked = lock_active_ff;
  assign lock_programmed = nv_lock_ff;
  assign mode_config = mode_ff;
  assign output_format_select = mode_ff[`FORMAT_MSB:`FORMAT_LSB];
  assign user_store_image = {user_store_ff[3], user_store_ff[2], user_store_ff[1], user_store_ff[0]};

endmodule

// ---- core/config_store_params.svh ----
// How it works
// - Four user store words, 13 bits each
// - Lock freezes registers, telegrams are ignored
// - New lock acts after next power cycle
// - Lock bit can never be cleared by a telegram, only by the factory fill
// - Locked device answers no command at all
// - Read-only 14-bit processed field word
// - Field word returned with bits reversed
// - Field word reads zero outside plain analog
// - Unlocked device reprogrammable any number of times
// - Format select at bits 7:5, 000 analog
`ifndef CONFIG_STORE_PARAMS_SVH
`define CONFIG_STORE_PARAMS_SVH

// Register indices on the command port
`define ADDR_USER_STORE0 4'h0
`define ADDR_USER_STORE1 4'h1
`define ADDR_USER_STORE2 4'h2
`define ADDR_USER_STORE3 4'h3
`define ADDR_MODE_CONFIG 4'h4
`define ADDR_PERMANENT_LOCK 4'h5
`define ADDR_FIELD_VALUE 4'h6

// Field layout
`define USER_STORE_W 13
`define USER_STORE_WORDS 4
`define FIELD_W 14
`define MODE_W 10
`define DATA_W 16
`define FORMAT_MSB 7
`define FORMAT_LSB 5
`define FORMAT_PLAIN_ANALOG 3'h0

// Reset values
`define MODE_RESET 10'h000
`define DATA_ZERO 16'h0000

`endif

// ---- core/config_store_pkg.sv ----
package config_store_pkg;
  // Kind of a decoded telegram
  typedef enum logic [1:0] {
    CMD_READ,
    CMD_WRITE,
    CMD_STORE,
    CMD_NONE
  } cmd_kind_e;

  // One decoded telegram from the supply demodulator
  typedef struct packed {
    logic valid;
    cmd_kind_e kind;
    logic [3:0] addr;
    logic [15:0] data;
  } cmd_s;

  // Answer sent back over the output pin
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } rsp_s;
endpackage

// ---- tb/config_store_props.sv ----
`timescale 1ns/1ps
module config_store_props
  import config_store_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire cmd_s cmd,
  input wire logic [13:0] field_value,
  input wire rsp_s rsp,
  input wire logic locked,
  input wire logic lock_programmed,
  input wire logic [9:0] mode_config,
  input wire logic [2:0] output_format_select,
  input wire logic [51:0] user_store_image
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic rst_d_ff; // Marks the lock sample cycle
  logic [13:0] rev; // Field word mirrored
  always_ff @(posedge clk) rst_d_ff <= rst;
  always_comb rev = {<<{field_value}};
  // Read taken: not locked, not in the sample cycle
  wire rd = cmd.valid && !locked && !rst_d_ff && cmd.kind == CMD_READ;
  // Write taken under the same terms
  wire wr = cmd.valid && !locked && !rst_d_ff && cmd.kind == CMD_WRITE;
  logic [12:0] word_now [4]; // Image split into words
  always_comb
    for (int i = 0; i < 4; i++)
      word_now[i] = user_store_image[13 * i +: 13];
  chk_read_answer: assert property (rd |=> rsp.valid) else $error("no answer");
  chk_no_stray: assert property (rsp.valid |-> $past(rd)) else $error("stray answer");
  chk_field_word: assert property (rd && cmd.addr == 4'h6 |=>
    rsp.data == ($past(output_format_select) == 3'h0 ? {2'h0, $past(rev)} : 16'h0000)) else $error("field");
  chk_lock_sticky: assert property (lock_programmed |=> lock_programmed) else $error("lock cleared");
  chk_lock_held: assert property (locked |=> locked && lock_programmed) else $error("lock lost");
  chk_lock_later: assert property ($rose(lock_programmed) |-> !locked) else $error("lock early");
  chk_frozen_regs: assert property (locked |=> $stable(user_store_image) && $stable(mode_config))
    else $error("changed while locked");
  chk_format_bits: assert property (output_format_select == mode_config[7:5]) else $error("format");
  chk_mode_write: assert property (wr && cmd.addr == 4'h4 |=> mode_config == $past(cmd.data[9:0]))
    else $error("mode write lost");
  chk_word_write: assert property (wr && cmd.addr < 4'h4 |=>
    word_now[$past(cmd.addr[1:0])] == $past(cmd.data[12:0])) else $error("word write lost");
  chk_locked_silent: assert property (locked |=> !rsp.valid) else $error("answer while locked");
  cover property (rd ##1 rsp.valid);
  cover property ($rose(locked));
  cover property (locked && cmd.valid);
  cover property (rd && cmd.addr == 4'h6 && output_format_select != 3'h0);
endmodule
bind config_store_lock_readout config_store_props config_store_props_i (.clk(clk), .rst(rst), .cmd(cmd),
  .field_value(field_value), .rsp(rsp), .locked(locked), .lock_programmed(lock_programmed),
  .mode_config(mode_config), .output_format_select(output_format_select), .user_store_image(user_store_image));

// ---- tb/programmer_model.sv ----
`timescale 1ns/1ps
module programmer_model
  import config_store_pkg::*;
(
  input wire logic clk,
  output cmd_s cmd
);
  initial cmd = '0;
  // One telegram; idle payload inverted so stale data never reads as valid
  task automatic send(input cmd_kind_e k, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 cmd = '{1'b1, k, a, d};
    @(posedge clk);
    #1 cmd = '{1'b0, CMD_NONE, ~a, ~d};
  endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  import config_store_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic nvm_init = 1;
  logic [13:0] field_value = '0;
  cmd_s cmd;
  rsp_s rsp;
  logic locked;
  logic lock_programmed;
  logic [9:0] mode_config;
  logic [2:0] fmt_sel;
  logic [51:0] user_store_image;
  logic [12:0] w [4] = '{13'h0000, 13'h0001, 13'h0002, 13'h0003}; // Factory defaults
  logic [15:0] exq [$]; // Expected answers, oldest first
  int n_mismatch = 0;
  int comparisons = 0;
  always #4 clk = ~clk;
  programmer_model programmer_model_i (.clk(clk), .cmd(cmd));
  config_store_lock_readout config_store_lock_readout_i (.clk(clk), .rst(rst), .nvm_init(nvm_init), .cmd(cmd),
    .field_value(field_value), .rsp(rsp), .locked(locked), .lock_programmed(lock_programmed),
    .mode_config(mode_config), .output_format_select(fmt_sel), .user_store_image(user_store_image));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Reads that must stay silent push nothing
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input bit answered);
    if (answered)
      exq.push_back(exp);
    programmer_model_i.send(CMD_READ, a, 16'h0000);
  endtask
  task automatic pwr;
    @(posedge clk);
    #1 rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    repeat (2) @(posedge clk);
  endtask
  // Any answer with nothing expected is a mismatch; looked at mid-cycle, where it stands
  always @(negedge clk)
    if (rsp.valid === 1'b1)
    begin
      if (exq.size() > 0)
        check(rsp.data, exq.pop_front());
      else
        check({15'h0000, rsp.valid}, 16'h0000);
    end
  task automatic wrap_up;
    check(16'(exq.size()), 16'h0000);
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    logic [13:0] f;
    void'($urandom(27));
    repeat (2) @(posedge clk);
    #1 nvm_init = 0;
    repeat (4) @(posedge clk);
    #1 rst = 0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 4; i++)
      rd(i[3:0], {3'h0, w[i]}, 1);
    for (int i = 0; i < 4; i++)
    begin
      w[i] = 13'($urandom);
      programmer_model_i.send(CMD_WRITE, i[3:0], {3'h0, w[i]});
    end
    programmer_model_i.send(CMD_STORE, 4'h0, 16'h0000);
    pwr();
    for (int i = 0; i < 4; i++)
    begin
      rd(i[3:0], {3'h0, w[i]}, 1);
      check({3'h0, user_store_image[13 * i +: 13]}, {3'h0, w[i]});
    end
    // Two-point readout, run twice as a recalibration restarts from scratch
    for (int p = 0; p < 2; p++)
    begin
      // Plain format set up before any readout
      programmer_model_i.send(CMD_WRITE, 4'h4, 16'h0000);
      for (int k = 0; k < 2; k++)
      begin
        // Low end, then high end of the range
        field_value = {k[0], k[0], 12'($urandom)};
        f = {<<{field_value}};
        rd(4'h6, {2'h0, f}, 1);
      end
      programmer_model_i.send(CMD_WRITE, 4'h6, 16'($urandom));
    end
    for (int m = 0; m < 8; m++)
    begin
      field_value = 14'($urandom);
      f = {<<{field_value}};
      programmer_model_i.send(CMD_WRITE, 4'h4, 16'(m) << 5);
      rd(4'h6, m == 0 ? {2'h0, f} : 16'h0000, 1);
    end
    check({6'h00, mode_config}, 16'h00e0);
    check({13'h0000, fmt_sel}, 16'h0007);
    rd(4'h4, 16'h00e0, 1);
    rd(4'h7, 16'h0000, 1);
    programmer_model_i.send(CMD_WRITE, 4'h5, 16'h0000);
    rd(4'h5, 16'h0000, 1);
    programmer_model_i.send(CMD_WRITE, 4'h5, 16'h0001);
    check({15'h0, lock_programmed}, 16'h0001);
    rd(4'h0, {3'h0, w[0]}, 1);
    rd(4'h5, 16'h0001, 1);
    pwr();
    check({15'h0, locked}, 16'h0001);
    rd(4'h0, 16'h0000, 0);
    programmer_model_i.send(CMD_WRITE, 4'h4, 16'h00e0);
    programmer_model_i.send(CMD_WRITE, 4'h0, {3'h0, ~w[0]});
    programmer_model_i.send(CMD_STORE, 4'h0, 16'h0000);
    check({6'h00, mode_config}, 16'h0000);
    check({3'h0, user_store_image[12:0]}, {3'h0, w[0]});
    pwr();
    check({15'h0, locked}, 16'h0001);
    check({3'h0, user_store_image[12:0]}, {3'h0, w[0]});
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule
